// [hdl/gpp_port.sv]
// Eight-pin GPIO port with pad configuration, interrupts and Avalon-MM slave
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
// What this block does
// - Eight-bit select mask, bit n is pin n
// - Read returns live level of selected pins
// - Unselected and upper read bits are zero
// - Status readable raw or masked by selector
// - Enable unmasks selected pins only
// - Disable masks selected pins only
// - Clear drops pending bits of selected pins
// - Per-pin drive strength, four choices
// - Per-pin pad type, seven choices
// - Pad settings stored even for inputs
// - Pad configuration reads back as written
// - Digital input enable resets off, required
// - Direction: input, output or peripheral
// - Trigger: falling, rising, both, low, high
// - Write changes only selected output and peripheral pins
module gpp_port
  import gpp_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  input wire logic [7:0] periph_out,
  input wire logic [7:0] periph_oe,
  output logic [7:0] periph_in,
  output logic [15:0] drive_strength_setting,
  output logic [23:0] pad_type_setting,
  output logic [7:0] digital_enable,
  output logic irq
);
  logic [7:0] pin_select_mask;
  logic [7:0] out_value;
  logic [7:0] int_unmask;
  logic [7:0] raw_status;
  logic [7:0] clear_req;
  logic [7:0] pin_level;
  logic status_form_select;
  logic [INDEX_W-1:0] single_pin_number;
  gpp_dir_t dir_mode [NUM_PINS];
  gpp_trig_t trig_type [NUM_PINS];
  gpp_strength_t strength [NUM_PINS];
  gpp_padtype_t padtype [NUM_PINS];
  logic ack;
  logic wr;
  logic [7:0] wbyte;
  logic [31:0] next_readdata;
  logic next_err;

  // ****************************************
  // Bus handshake
  // ****************************************
  // One wait cycle per access: request taken, answer the next edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr = avs_write & ~ack & clk_en & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ack <= 1'b0;
    end else if (clk_en) begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  // ****************************************
  // Pin level and pad drive
  // ****************************************
  // Inputs read as zero while the digital input enable is off
  assign pin_level = pin_in & digital_enable;
  assign periph_in = pin_level;

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_out[i] = 1'b0;
      pin_oe_n[i] = 1'b1;
      drive_strength_setting[2*i +: 2] = strength[i];
      pad_type_setting[3*i +: 3] = padtype[i];
      if (padtype[i] != GPP_ANALOG_TYPE && digital_enable[i]) begin
        if (dir_mode[i] == GPP_PERIPHERAL_CONTROLLED_MODE) begin
          pin_out[i] = periph_out[i];
          pin_oe_n[i] = ~periph_oe[i];
        end else if (dir_mode[i] == GPP_DIR_OUT) begin
          pin_out[i] = out_value[i];
          pin_oe_n[i] = 1'b0;
        end
        // Open drain only pulls low, high is left to the pull-up
        if (padtype[i] inside {GPP_OPEN_DRAIN_TYPE, GPP_OPEN_DRAIN_WEAK_PULL_UP,
                               GPP_OPEN_DRAIN_WEAK_PULL_DOWN}) begin
          pin_oe_n[i] = pin_oe_n[i] | pin_out[i];
          pin_out[i] = 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Selection and control registers
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_select_mask <= RST_BYTE;
      status_form_select <= 1'b0;
      single_pin_number <= '0;
    end else if (wr) begin
      if (avs_address == OFS_SELECT) begin
        pin_select_mask <= wbyte;
      end else if (avs_address == OFS_INT_STATUS) begin
        status_form_select <= avs_writedata[FORM_BIT];
      end else if (avs_address == OFS_PIN_INDEX) begin
        single_pin_number <= avs_writedata[INDEX_W-1:0];
      end
    end
  end

  // Output latch; writes to pins set as inputs are dropped, other selected pins take the bit
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_value <= RST_BYTE;
    end else if (wr && avs_address == OFS_PIN_WRITE) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (pin_select_mask[i] && dir_mode[i] != GPP_DIR_IN) begin
          out_value[i] <= wbyte[i];
        end
      end
    end
  end

  // Per-pin direction, trigger and pad settings, applied to selected pins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        dir_mode[i] <= GPP_DIR_IN;
        trig_type[i] <= GPP_TRIG_FALLING;
        strength[i] <= GPP_DRIVE_2MA;
        padtype[i] <= GPP_PUSH_PULL_TYPE;
      end
    end else if (wr) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (pin_select_mask[i]) begin
          if (avs_address == OFS_DIR_SET && avs_writedata[1:0] != 2'h3) begin
            dir_mode[i] <= gpp_dir_t'(avs_writedata[1:0]);
          end else if (avs_address == OFS_INT_TYPE_SET && avs_writedata[2:0] <= 3'h4) begin
            trig_type[i] <= gpp_trig_t'(avs_writedata[2:0]);
          end else if (avs_address == OFS_PAD_SET && avs_writedata[6:4] != 3'h7) begin
            strength[i] <= gpp_strength_t'(avs_writedata[STRENGTH_LSB +: 2]);
            padtype[i] <= gpp_padtype_t'(avs_writedata[PADTYPE_LSB +: 3]);
          end
        end
      end
    end
  end

  // Digital enable defaults off so pads come up isolated
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      digital_enable <= RST_BYTE;
    end else if (wr && avs_address == OFS_DIGITAL_EN) begin
      digital_enable <= wbyte;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      int_unmask <= RST_BYTE;
    end else if (wr && avs_address == OFS_INT_ENABLE) begin
      int_unmask <= int_unmask | (wbyte & pin_select_mask);
    end else if (wr && avs_address == OFS_INT_DISABLE) begin
      int_unmask <= int_unmask & ~(wbyte & pin_select_mask);
    end
  end

  // Clear takes effect on selected pins; write-one-to-clear on the status word too
  always_comb begin
    clear_req = 8'h00;
    if (wr && avs_address == OFS_INT_CLEAR) begin
      clear_req = wbyte & pin_select_mask;
    end else if (wr && avs_address == OFS_INT_STATUS) begin
      clear_req = avs_writedata[15:8];
    end
  end

  for (genvar g = 0; g < NUM_PINS; g++) begin : g_det
    gpp_pin_detect u_det (
      .mclk(mclk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .pin_level(pin_level[g]),
      .trig_type(trig_type[g]),
      .clear_req(clear_req[g]),
      .raw_status(raw_status[g])
    );
  end

  // Level output; source stays visible until a clear lands
  assign irq = |(raw_status & int_unmask);

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    next_readdata = RST_WORD;
    next_err = 1'b0;
    if (avs_address == OFS_SELECT) begin
      next_readdata[7:0] = pin_select_mask;
    end else if (avs_address == OFS_DATA) begin
      next_readdata[7:0] = pin_level & pin_select_mask;
    end else if (avs_address == OFS_PIN_WRITE) begin
      next_readdata[7:0] = out_value;
    end else if (avs_address == OFS_INT_ENABLE) begin
      next_readdata[7:0] = int_unmask;
    end else if (avs_address == OFS_INT_STATUS) begin
      next_readdata[7:0] = status_form_select ? (raw_status & int_unmask) : raw_status;
    end else if (avs_address == OFS_PIN_CFG) begin
      next_readdata[STRENGTH_LSB +: 2] = strength[single_pin_number];
      next_readdata[PADTYPE_LSB +: 3] = padtype[single_pin_number];
      next_readdata[DIR_LSB +: 2] = dir_mode[single_pin_number];
      next_readdata[INTTYPE_LSB +: 3] = trig_type[single_pin_number];
    end else if (avs_address == OFS_DIGITAL_EN) begin
      next_readdata[7:0] = digital_enable;
    end else if (avs_address == OFS_PIN_INDEX) begin
      next_readdata[INDEX_W-1:0] = single_pin_number;
    end else if (!(avs_address inside {OFS_DIR_SET, OFS_INT_TYPE_SET, OFS_PAD_SET,
                                         OFS_INT_DISABLE, OFS_INT_CLEAR})) begin
      next_err = 1'b1;
    end
  end

  // Read data and response registered at the taking edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= RST_WORD;
      avs_response <= 2'b00;
    end else if (clk_en && (avs_read | avs_write) && !ack) begin
      avs_readdata <= avs_read ? next_readdata : RST_WORD;
      avs_response <= next_err ? 2'b11 : 2'b00;
    end
  end
endmodule

// [hdl/gpp_pkg.sv]
// Package with register map, field encodings and reset values of the GPIO port
package gpp_pkg;
  // ****************************************
  // Register byte offsets (one 32-bit word each)
  // ****************************************
  localparam logic [5:0] OFS_SELECT = 6'h00;
  localparam logic [5:0] OFS_DATA = 6'h04;
  localparam logic [5:0] OFS_PIN_WRITE = 6'h08;
  localparam logic [5:0] OFS_DIR_SET = 6'h0C;
  localparam logic [5:0] OFS_INT_TYPE_SET = 6'h10;
  localparam logic [5:0] OFS_PAD_SET = 6'h14;
  localparam logic [5:0] OFS_INT_ENABLE = 6'h18;
  localparam logic [5:0] OFS_INT_DISABLE = 6'h1C;
  localparam logic [5:0] OFS_INT_CLEAR = 6'h20;
  localparam logic [5:0] OFS_INT_STATUS = 6'h24;
  localparam logic [5:0] OFS_PIN_CFG = 6'h28;
  localparam logic [5:0] OFS_DIGITAL_EN = 6'h2C;
  localparam logic [5:0] OFS_PIN_INDEX = 6'h30;

  // ****************************************
  // Field positions and widths
  // ****************************************
  localparam int NUM_PINS = 8;
  localparam int DATA_W = 32;
  localparam int STRENGTH_LSB = 0;
  localparam int PADTYPE_LSB = 4;
  localparam int DIR_LSB = 8;
  localparam int INTTYPE_LSB = 12;
  localparam int FORM_BIT = 0;
  localparam int INDEX_W = 3;

  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0] {
    GPP_DRIVE_2MA, GPP_DRIVE_4MA, GPP_DRIVE_8MA, GPP_DRIVE_8MA_SLEW_LIMITED
  } gpp_strength_t;
  typedef enum logic [2:0] {
    GPP_PUSH_PULL_TYPE, GPP_PUSH_PULL_WEAK_PULL_UP, GPP_PUSH_PULL_WEAK_PULL_DOWN,
    GPP_OPEN_DRAIN_TYPE, GPP_OPEN_DRAIN_WEAK_PULL_UP, GPP_OPEN_DRAIN_WEAK_PULL_DOWN,
    GPP_ANALOG_TYPE
  } gpp_padtype_t;
  typedef enum logic [1:0] {
    GPP_DIR_IN, GPP_DIR_OUT, GPP_PERIPHERAL_CONTROLLED_MODE
  } gpp_dir_t;
  typedef enum logic [2:0] {
    GPP_TRIG_FALLING, GPP_TRIG_RISING, GPP_TRIG_BOTH, GPP_TRIG_LOW, GPP_TRIG_HIGH
  } gpp_trig_t;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

// [hdl/gpp_pin_detect.sv]
// Per-pin trigger detector and sticky raw interrupt status bit
`timescale 1ns/10ps
module gpp_pin_detect
  import gpp_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic pin_level,
  input wire gpp_trig_t trig_type,
  input wire logic clear_req,
  output logic raw_status
);
  logic prev_level;
  logic hit;

  // Previous level for edge detection
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prev_level <= 1'b0;
    end else if (clk_en) begin
      prev_level <= pin_level;
    end
  end

  // Trigger decode, one of five types
  always_comb begin
    case (trig_type)
      GPP_TRIG_FALLING: hit = prev_level & ~pin_level;
      GPP_TRIG_RISING: hit = ~prev_level & pin_level;
      GPP_TRIG_BOTH: hit = prev_level ^ pin_level;
      GPP_TRIG_LOW: hit = ~pin_level;
      GPP_TRIG_HIGH: hit = pin_level;
      default: hit = 1'b0;
    endcase
  end

  // Sticky status; a new trigger wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      raw_status <= 1'b0;
    end else if (clk_en) begin
      if (hit) begin
        raw_status <= 1'b1;
      end else if (clear_req) begin
        raw_status <= 1'b0;
      end
    end
  end
endmodule

// [verif/gpp_board.sv]
// Board-side model of the eight pads seen by the GPIO port
`timescale 1ns/10ps
module gpp_board (
  input wire logic [7:0] board_drive,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  output logic [7:0] pin_in
);
  // Pad level: the port wins where it drives, the board source elsewhere
  assign pin_in = (pin_out & ~pin_oe_n) | (board_drive & pin_oe_n);
endmodule

// [verif/gpp_chk.sv]
// Checker of bus answers and register side effects of the GPIO port
`timescale 1ns/10ps
module gpp_chk
  import gpp_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic [15:0] drive_strength_setting,
  input wire logic [23:0] pad_type_setting,
  input wire logic [7:0] digital_enable,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic req;
  logic done;
  logic bad;
  // Access in flight, answered, and beyond the map
  assign req = avs_read | avs_write;
  assign done = req & !avs_waitrequest;
  assign bad = avs_address > OFS_PIN_INDEX;
  // ********
  // Assertions
  // ********
  chk_one_wait: assert property ($rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait cycle count wrong");
  chk_data_hi_zero: assert property (done && avs_read && avs_address == OFS_DATA |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("pin read upper bits set");
  chk_stat_hi_zero: assert property (done && avs_read && avs_address == OFS_INT_STATUS |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("status upper bits set");
  chk_bad_resp: assert property (done && bad |-> avs_response == 2'h3)
    else $error("unmapped access not refused");
  chk_bad_zero: assert property (done && avs_read && bad |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_ok_resp: assert property (done && !bad && avs_address[1:0] == 2'h0 |-> avs_response == 2'h0)
    else $error("mapped access refused");
  chk_den_hold: assert property ($changed(digital_enable) |-> $past(avs_write && avs_address == OFS_DIGITAL_EN))
    else $error("digital enable changed unasked");
  chk_pad_hold: assert property ($changed({drive_strength_setting, pad_type_setting}) |-> $past(avs_write && avs_address == OFS_PAD_SET))
    else $error("pad setting changed unasked");
  chk_irq_fall: assert property ($fell(irq) |-> $past(avs_write))
    else $error("irq dropped without a write");
  // Main scenarios reached
  cover property ($rose(irq));
  cover property ($fell(irq));
  cover property (done && bad);
endmodule
bind gpp_port gpp_chk chk_i (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .drive_strength_setting(drive_strength_setting), .pad_type_setting(pad_type_setting),
  .digital_enable(digital_enable), .irq(irq));

// [verif/tb.sv]
// Self-checking bench of the GPIO port through its Avalon-MM slave
`timescale 1ns/10ps
module tb;
  import gpp_pkg::*;
  localparam logic [4:0] IDLE_LVL = 5'h0d;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic [7:0] board_drive = 8'h00;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe_n;
  logic [7:0] periph_in;
  logic [7:0] digital_enable;
  logic [15:0] drive_strength_setting;
  logic [23:0] pad_type_setting;
  logic irq;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  int n_fail = 0;
  int total_checks = 0;
  gpp_port dut (.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .periph_out(8'h00), .periph_oe(8'h00), .periph_in(periph_in),
    .drive_strength_setting(drive_strength_setting), .pad_type_setting(pad_type_setting),
    .digital_enable(digital_enable), .irq(irq));
  gpp_board board (.board_drive(board_drive), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_in(pin_in));
  // ********
  // Clock, tasks and watchdog
  // ********
  initial begin
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One access; held until waitrequest is sampled low, bounded wait
  task automatic bus(input logic wr, input logic [5:0] addr, input logic [31:0] data);
    int n;
    @(posedge mclk);
    avs_address <= addr;
    avs_writedata <= data;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd_data = avs_readdata;
    rd_resp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) chk("bus answer", 32'h0000_0000, 32'h0000_0001);
  endtask
  task automatic rdchk(input string name, input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(name, rd_data, exp);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Far above the few hundred cycles the sequence needs
  initial begin
    #200000;
    n_fail++;
    report_and_stop;
  end
  // ********
  // Test sequence
  // ********
  initial begin
    logic [31:0] exp;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    rdchk("select", OFS_SELECT, 32'h0000_0000);
    rdchk("digital en", OFS_DIGITAL_EN, 32'h0000_0000);
    chk("oe_n reset", 32'(pin_oe_n), 32'h0000_00ff);
    chk("irq reset", 32'(irq), 32'h0000_0000);
    bus(1'b0, 6'h34, 32'h0000_0000);
    chk("bad data", rd_data, 32'h0000_0000);
    chk("bad resp", 32'(rd_resp), 32'h0000_0003);
    // Pin read with a sparse mask over board levels
    bus(1'b1, OFS_DIGITAL_EN, 32'h0000_00ff);
    board_drive <= 8'ha5;
    bus(1'b1, OFS_SELECT, 32'h0000_0009);
    rdchk("data sel", OFS_DATA, 32'h0000_0001);
    bus(1'b1, OFS_SELECT, 32'h0000_000f);
    bus(1'b1, OFS_DIR_SET, 32'h0000_0001);
    bus(1'b1, OFS_SELECT, 32'h0000_0080);
    bus(1'b1, OFS_DIR_SET, 32'h0000_0002);
    chk("oe_n dir", 32'(pin_oe_n), 32'h0000_00f0);
    // Writes to input pins are lost, outputs follow only where selected
    bus(1'b1, OFS_SELECT, 32'h0000_00f0);
    bus(1'b1, OFS_PIN_WRITE, 32'h0000_00ff);
    bus(1'b1, OFS_SELECT, 32'h0000_0003);
    bus(1'b1, OFS_PIN_WRITE, 32'h0000_00ff);
    chk("driven", 32'(pin_out & ~pin_oe_n), 32'h0000_0003);
    bus(1'b1, OFS_SELECT, 32'h0000_00ff);
    rdchk("data all", OFS_DATA, 32'h0000_00a3);
    chk("periph in", 32'(periph_in), 32'h0000_00a3);
    // Pad settings on outputs, inputs and the peripheral pin
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, OFS_SELECT, 32'(1 << i));
      bus(1'b1, OFS_PAD_SET, 32'(((i % 7) << 4) | (i % 4)));
    end
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, OFS_PIN_INDEX, 32'(i));
      exp = 32'(((i % 7) << 4) | (i % 4) | ((i < 4 ? 1 : (i == 7 ? 2 : 0)) << 8));
      rdchk("pin cfg", OFS_PIN_CFG, exp);
      chk("strength", 32'(drive_strength_setting[2*i +: 2]), 32'(i % 4));
      chk("pad type", 32'(pad_type_setting[3*i +: 3]), 32'(i % 7));
    end
    // Every trigger kind on input pin 5; pins 0 and 2 fell when driven, so clear all first
    bus(1'b1, OFS_SELECT, 32'h0000_00ff);
    bus(1'b1, OFS_INT_CLEAR, 32'h0000_00ff);
    rdchk("raw all clr", OFS_INT_STATUS, 32'h0000_0000);
    bus(1'b1, OFS_SELECT, 32'h0000_0020);
    for (int t = 0; t < 5; t++) begin
      board_drive[5] <= IDLE_LVL[t];
      repeat (3) @(posedge mclk);
      bus(1'b1, OFS_INT_TYPE_SET, 32'(t));
      bus(1'b1, OFS_INT_CLEAR, 32'h0000_00ff);
      rdchk("raw idle", OFS_INT_STATUS, 32'h0000_0000);
      board_drive[5] <= !IDLE_LVL[t];
      repeat (3) @(posedge mclk);
      rdchk("raw hit", OFS_INT_STATUS, 32'h0000_0020);
    end
    // One sticky rising event, then mask, unmask and clear
    board_drive[5] <= 1'b0;
    repeat (3) @(posedge mclk);
    bus(1'b1, OFS_INT_TYPE_SET, 32'h0000_0001);
    bus(1'b1, OFS_INT_CLEAR, 32'h0000_00ff);
    board_drive[5] <= 1'b1;
    repeat (3) @(posedge mclk);
    bus(1'b1, OFS_SELECT, 32'h0000_00df);
    bus(1'b1, OFS_INT_ENABLE, 32'h0000_00ff);
    chk("irq masked", 32'(irq), 32'h0000_0000);
    bus(1'b1, OFS_SELECT, 32'h0000_0020);
    bus(1'b1, OFS_INT_ENABLE, 32'h0000_00ff);
    chk("irq on", 32'(irq), 32'h0000_0001);
    bus(1'b1, OFS_INT_STATUS, 32'h0000_0001);
    rdchk("masked", OFS_INT_STATUS, 32'h0000_0020);
    bus(1'b1, OFS_INT_DISABLE, 32'h0000_00ff);
    chk("irq off", 32'(irq), 32'h0000_0000);
    rdchk("masked off", OFS_INT_STATUS, 32'h0000_0000);
    bus(1'b1, OFS_INT_STATUS, 32'h0000_0000);
    rdchk("raw kept", OFS_INT_STATUS, 32'h0000_0020);
    bus(1'b1, OFS_INT_ENABLE, 32'h0000_00ff);
    // Clearing with pin 5 unselected keeps irq, clearing pin 5 then drops it
    bus(1'b1, OFS_SELECT, 32'h0000_00df);
    bus(1'b1, OFS_INT_CLEAR, 32'h0000_00ff);
    chk("irq kept", 32'(irq), 32'h0000_0001);
    bus(1'b1, OFS_SELECT, 32'h0000_0020);
    bus(1'b1, OFS_INT_CLEAR, 32'h0000_00ff);
    chk("irq clr", 32'(irq), 32'h0000_0000);
    report_and_stop;
  end
endmodule
